// ### verilog/flash_pkg.sv
// Purpose: constants and types for the flash program/erase control block
// Assumes: 8-bit cpu bus with 16-bit addresses, one access per cycle
// Notes:   flash_control at 0xfe08, flash_protect_start byte at 0xff7e
package flash_pkg;
  localparam logic [15:0] control_addr   = 16'hfe08;
  localparam logic [15:0] protect_addr   = 16'hff7e;
  localparam logic [15:0] user_lo_addr   = 16'h8000;
  localparam logic [15:0] user_hi_addr   = 16'hfdff;
  localparam logic [15:0] vector_lo_addr = 16'hffdc;
  localparam logic [15:0] vector_hi_addr = 16'hffff;
  localparam int          hv_bit         = 3;
  localparam int          mass_bit       = 2;
  localparam int          erase_bit      = 1;
  localparam int          prog_bit       = 0;
  localparam logic [3:0]  control_reset  = 4'h0;
  localparam logic [7:0]  erased_byte    = 8'hff;
  localparam logic [7:0]  protect_none   = 8'hff;
  localparam int          row_shift      = 6;
  localparam int          page_shift     = 7;

  typedef enum logic [1:0] {st_idle, st_selected, st_armed, st_active} seq_t;

  typedef struct packed {
    logic [3:0]  ctrl;
    seq_t        seq;
    logic        protect_read;
    logic [15:0] latch_addr;
    logic [7:0]  latch_data;
    logic        row_fail;
    logic        hv_on;
    logic        erase_pulse;
    logic        mass_pulse;
    logic        prog_pulse;
    logic [15:0] op_addr;
    logic [7:0]  op_data;
    logic [7:0]  rdata;
    logic [7:0]  protect_shadow;
  } flash_state_t;
endpackage

// ### verilog/flash_program_erase_control.sv
// Purpose: control logic for program, page erase and mass erase of the flash
// Assumes: cpu bus reads return data one cycle after rd_en; array is external
// Notes:   array reads come in on array_rdata; pulses drive the array macro
`timescale 1ns/1ns
module flash_program_erase_control
  import flash_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] addr,
  input  wire logic        rd_en,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  array_rdata,
  input  wire logic [7:0]  protect_byte,
  output logic      [7:0]  rdata,
  output logic             high_voltage_enable,
  output logic             erase_strobe,
  output logic             mass_strobe,
  output logic             program_strobe,
  output logic      [15:0] op_addr,
  output logic      [7:0]  op_data,
  output logic             row_fail
);

  // ==========================================================
  // helpers
  function automatic logic in_flash(input logic [15:0] a);
    in_flash = (a >= user_lo_addr && a <= user_hi_addr) ||
               (a >= vector_lo_addr && a <= vector_hi_addr) ||
               (a == protect_addr);
  endfunction

  function automatic logic [15:0] protect_start(input logic [7:0] bits);
    protect_start = {1'b1, bits, 7'h00};
  endfunction

  function automatic logic is_protected(input logic [15:0] a, input logic [7:0] bits);
    is_protected = (bits != protect_none) && (a >= protect_start(bits));
  endfunction

  function automatic logic same_row(input logic [15:0] a, input logic [15:0] b);
    same_row = (a[15:row_shift] == b[15:row_shift]);
  endfunction

  function automatic logic [15:0] page_base(input logic [15:0] a);
    page_base = {a[15:page_shift], 7'h00};
  endfunction

  // ==========================================================
  // state
  flash_state_t state_reg;
  flash_state_t state_next;

  logic        ctrl_wr;
  logic        flash_wr;
  logic [3:0]  wctrl;
  logic        hv_ok;

  always_comb begin
    state_next  = state_reg;
    ctrl_wr     = wr_en && (addr == control_addr);
    flash_wr    = wr_en && in_flash(addr);
    wctrl       = wdata[3:0];
    hv_ok       = 1'b0;
    state_next.erase_pulse = 1'b0;
    state_next.mass_pulse  = 1'b0;
    state_next.prog_pulse  = 1'b0;
    state_next.protect_shadow = protect_byte;

    // read path
    if (rd_en && addr == control_addr) begin
      state_next.rdata = {4'h0, state_reg.ctrl};
    end else if (rd_en && in_flash(addr)) begin
      state_next.rdata = array_rdata;
    end else if (rd_en) begin
      state_next.rdata = 8'h00;
    end

    // reading the protect byte in st_selected lets the next flash write arm the sequence
    if (rd_en && addr == protect_addr && state_reg.seq == st_selected) begin
      state_next.protect_read = 1'b1;
    end

    if (ctrl_wr) begin
      // erase wins if both are requested
      state_next.ctrl[erase_bit] = wctrl[erase_bit];
      state_next.ctrl[prog_bit]  = wctrl[prog_bit] && !wctrl[erase_bit];
      state_next.ctrl[mass_bit]  = wctrl[mass_bit];
      if (state_reg.ctrl[erase_bit] && !wctrl[erase_bit] && !wctrl[prog_bit]) begin
        state_next.ctrl[prog_bit] = 1'b0;
      end
      // the write that raises high voltage must leave the select bits as they are
      hv_ok = (state_reg.ctrl[erase_bit] || state_reg.ctrl[prog_bit]) &&
              wctrl[erase_bit] == state_reg.ctrl[erase_bit] &&
              wctrl[prog_bit] == state_reg.ctrl[prog_bit] &&
              state_reg.seq == st_armed &&
              !is_protected(state_reg.latch_addr, protect_byte) &&
              !(state_reg.ctrl[mass_bit] && state_reg.ctrl[erase_bit] &&
                protect_byte != protect_none);
      if (wctrl[hv_bit] && !state_reg.ctrl[hv_bit]) begin
        state_next.ctrl[hv_bit] = hv_ok;
      end else begin
        state_next.ctrl[hv_bit] = wctrl[hv_bit];
      end
      if (!wctrl[erase_bit] && !wctrl[prog_bit]) begin
        state_next.seq          = st_idle;
        state_next.protect_read = 1'b0;
        state_next.row_fail     = state_reg.row_fail;
      end else if (state_reg.seq == st_idle) begin
        state_next.seq      = st_selected;
        state_next.row_fail = 1'b0;
      end
      if (hv_ok && wctrl[hv_bit] && !state_reg.ctrl[hv_bit]) begin
        state_next.seq = st_active;
        if (state_reg.ctrl[erase_bit]) begin
          state_next.erase_pulse = 1'b1;
          state_next.mass_pulse  = state_reg.ctrl[mass_bit];
          state_next.op_addr     = state_reg.ctrl[mass_bit] ? user_lo_addr :
            page_base(state_reg.latch_addr);
        end
      end
    end else if (flash_wr) begin
      // unrelated accesses pass without effect on the sequence
      if (state_reg.seq == st_selected && state_reg.protect_read) begin
        state_next.latch_addr = addr;
        state_next.latch_data = wdata;
        state_next.seq        = st_armed;
      end else if (state_reg.seq == st_active && state_reg.ctrl[prog_bit] &&
                   state_reg.ctrl[hv_bit]) begin
        if (!same_row(addr, state_reg.latch_addr)) begin
          state_next.row_fail = 1'b1;
        end else if (!state_reg.row_fail) begin
          state_next.prog_pulse = 1'b1;
          state_next.op_addr    = addr;
          state_next.op_data    = wdata;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg                <= '0;
      state_reg.ctrl           <= control_reset;
      state_reg.seq            <= st_idle;
      state_reg.rdata          <= erased_byte;
      state_reg.protect_shadow <= protect_none;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  assign rdata               = state_reg.rdata;
  assign high_voltage_enable = state_reg.ctrl[hv_bit];
  assign erase_strobe        = state_reg.erase_pulse;
  assign mass_strobe         = state_reg.mass_pulse;
  assign program_strobe      = state_reg.prog_pulse;
  assign op_addr             = state_reg.op_addr;
  assign op_data             = state_reg.op_data;
  assign row_fail            = state_reg.row_fail;

  // ==========================================================
  // checks: control and high voltage
  a_interlock_never_both: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(state_reg.ctrl[erase_bit] && state_reg.ctrl[prog_bit]))
    else $error("erase and program both set");

  a_hv_needs_select: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(high_voltage_enable) |-> $past(state_reg.seq) == st_armed)
    else $error("high voltage without sequence");

  a_hv_select_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(high_voltage_enable) |->
      ($past(state_reg.ctrl[erase_bit]) || $past(state_reg.ctrl[prog_bit])))
    else $error("high voltage without erase or program selected");

  a_hv_keeps_select: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(high_voltage_enable) |-> (state_reg.ctrl[erase_bit] || state_reg.ctrl[prog_bit]))
    else $error("high voltage raised while select bits dropped");

  a_hv_on_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(high_voltage_enable) |-> $past(ctrl_wr))
    else $error("high voltage rose without a control write");

  a_hv_after_read: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(high_voltage_enable) |-> $past(state_reg.protect_read))
    else $error("high voltage before protect byte read");

  a_hv_protected_refused: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ctrl_wr && wdata[hv_bit] && !high_voltage_enable &&
     is_protected(state_reg.latch_addr, protect_byte)) |=> !high_voltage_enable)
    else $error("high voltage set in protected block");

  a_mass_refused: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ctrl_wr && wdata[hv_bit] && !high_voltage_enable && state_reg.ctrl[mass_bit] &&
     state_reg.ctrl[erase_bit] && protect_byte != protect_none) |=> !high_voltage_enable)
    else $error("high voltage set for mass erase while protected");

  a_ctrl_upper_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(rd_en) && $past(addr) == control_addr |-> rdata[7:4] == 4'h0)
    else $error("unused control bits read nonzero");

  a_ctrl_read_value: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(rd_en) && $past(addr) == control_addr |-> rdata[3:0] == $past(state_reg.ctrl))
    else $error("control read does not show control bits");

  a_flash_read_data: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(rd_en) && $past(addr) == protect_addr |-> rdata == $past(array_rdata))
    else $error("array read data not passed through");

  a_seq_needs_select: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_reg.seq != st_idle |-> (state_reg.ctrl[erase_bit] || state_reg.ctrl[prog_bit]))
    else $error("sequence running with nothing selected");

  a_read_arms_seq: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(state_reg.protect_read) |-> $past(state_reg.seq) == st_selected)
    else $error("protect read taken outside selection");

  // ==========================================================
  // checks: erase
  a_mass_inhibit: assert property (@(posedge sys_clk) disable iff (!rstn)
    mass_strobe |-> $past(protect_byte) == protect_none)
    else $error("mass erase while protected");

  a_shadow_unprotected: assert property (@(posedge sys_clk) disable iff (!rstn)
    mass_strobe |-> state_reg.protect_shadow == protect_none)
    else $error("mass erase with protect byte not all ones");

  a_mass_with_erase: assert property (@(posedge sys_clk) disable iff (!rstn)
    mass_strobe |-> erase_strobe)
    else $error("mass strobe without erase strobe");

  a_mass_base_addr: assert property (@(posedge sys_clk) disable iff (!rstn)
    mass_strobe |-> op_addr == user_lo_addr)
    else $error("mass erase address not array base");

  a_erase_needs_hv: assert property (@(posedge sys_clk) disable iff (!rstn)
    erase_strobe |-> high_voltage_enable)
    else $error("erase strobe without high voltage");

  a_erase_on_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    erase_strobe |-> $past(ctrl_wr))
    else $error("erase strobe without a control write");

  a_strobe_one_cycle: assert property (@(posedge sys_clk) disable iff (!rstn)
    erase_strobe |=> !erase_strobe)
    else $error("erase strobe longer than one cycle");

  a_page_aligned: assert property (@(posedge sys_clk) disable iff (!rstn)
    (erase_strobe && !mass_strobe) |-> op_addr[6:0] == 7'h00)
    else $error("page erase address not aligned");

  a_page_in_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
    (erase_strobe && !mass_strobe) |-> op_addr == page_base(state_reg.latch_addr))
    else $error("page erase not the latched page");

  a_page_unprotected: assert property (@(posedge sys_clk) disable iff (!rstn)
    (erase_strobe && !mass_strobe) |-> !is_protected(op_addr, state_reg.protect_shadow))
    else $error("page erase inside protected block");

  // ==========================================================
  // checks: program
  a_strobes_exclusive: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(erase_strobe && program_strobe))
    else $error("erase and program strobes together");

  a_prog_in_row: assert property (@(posedge sys_clk) disable iff (!rstn)
    program_strobe |-> same_row(op_addr, state_reg.latch_addr))
    else $error("program outside latched row");

  a_prog_needs_hv: assert property (@(posedge sys_clk) disable iff (!rstn)
    program_strobe |-> high_voltage_enable && state_reg.ctrl[prog_bit])
    else $error("program strobe without program mode and high voltage");

  a_prog_on_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    program_strobe |-> $past(flash_wr))
    else $error("program strobe without an array write");

  a_prog_data_taken: assert property (@(posedge sys_clk) disable iff (!rstn)
    program_strobe |-> op_data == $past(wdata) && op_addr == $past(addr))
    else $error("program byte or address not the written one");

  a_latch_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
    (flash_wr && state_reg.seq == st_selected && state_reg.protect_read) |=>
      (state_reg.latch_addr == $past(addr) && state_reg.latch_data == $past(wdata)))
    else $error("row write not captured");

  a_row_fail_blocks: assert property (@(posedge sys_clk) disable iff (!rstn)
    row_fail && $past(row_fail) |-> !program_strobe)
    else $error("programming after row failure");

  a_prog_row_ok: assert property (@(posedge sys_clk) disable iff (!rstn)
    program_strobe |-> !row_fail)
    else $error("program strobe with row failure set");

  a_fail_needs_prog: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(row_fail) |-> state_reg.ctrl[prog_bit])
    else $error("row failure outside program mode");

endmodule

// ### sim/test_flash_program_erase_control.sv
// Purpose: self-checking bench for the flash program/erase control block
// Assumes: cpu bus driven on rising edges; array reads echo protect_byte at protect_addr, erased_byte elsewhere
// Notes:   control writes run from a table, sequences are hand-written
`timescale 1ns/1ns
module test_flash_program_erase_control
  import flash_pkg::*;
  ;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  protect_byte = 8'hff;
  logic [7:0]  rdata;
  logic [7:0]  op_data;
  logic [15:0] op_addr;
  logic        hv, erase_strobe, mass_strobe, program_strobe, row_fail;
  int          errors = 0;
  int          num_checks = 0;
  // waits in 10 ns cycles; the holds are scaled down, the block keeps no timer
  localparam int nvs_cycles  = 1000;
  localparam int hold_cycles = 200;
  localparam int nvh_cycles  = 500;
  logic [7:0]  row_in  [7] = '{8'h03, 8'h01, 8'h02, 8'h06, 8'h0c, 8'h0f, 8'hf0};
  logic [7:0]  row_out [7] = '{8'h02, 8'h01, 8'h02, 8'h06, 8'h04, 8'h06, 8'h00};
  // array model: protect byte at its address, erased ones elsewhere
  wire  [7:0]  array_rdata = (addr == protect_addr) ? protect_byte : erased_byte;

  always #5 sys_clk = ~sys_clk;

  flash_program_erase_control dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
    .wdata(wdata), .array_rdata(array_rdata), .protect_byte(protect_byte),
    .rdata(rdata), .high_voltage_enable(hv), .erase_strobe(erase_strobe),
    .mass_strobe(mass_strobe), .program_strobe(program_strobe), .op_addr(op_addr),
    .op_data(op_data), .row_fail(row_fail));

  // ==========================================================
  // bus tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
  endtask
  task automatic do_reset(input logic [7:0] prot);
    @(posedge sys_clk);
    rstn <= 1'b0;
    protect_byte <= prot;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
  endtask
  // select, read protect, unrelated unmapped read, flash write, then hv
  task automatic arm(input logic [7:0] c, input logic [15:0] a);
    wr(control_addr, c);
    rd(protect_addr);
    rd(16'hfe09);
    chk(rdata, 8'h00);
    wr(a, 8'h55);
    repeat (nvs_cycles) @(posedge sys_clk);
    wr(control_addr, c | 8'h08);
  endtask
  // clear the select bits first, then high voltage
  task automatic drop_hv();
    repeat (hold_cycles) @(posedge sys_clk);
    wr(control_addr, 8'h08);
    rd(control_addr);
    chk(rdata, 8'h08);
    repeat (nvh_cycles) @(posedge sys_clk);
    wr(control_addr, 8'h00);
    rd(control_addr);
    chk(rdata, 8'h00);
    chk({erase_strobe, mass_strobe, program_strobe}, 3'h0);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    do_reset(8'hff);
    chk(rdata, 8'hff);
    chk({hv, erase_strobe, mass_strobe, program_strobe, row_fail}, 5'h00);
    rd(control_addr);
    chk(rdata, 8'h00);
    $display("reset done");
    for (int i = 0; i < 7; i++) begin
      wr(control_addr, row_in[i]);
      rd(control_addr);
      chk(rdata, row_out[i]);
      chk(hv, 1'b0);
    end
    $display("control table done");
    do_reset(8'hff);
    arm(8'h02, 16'h8123);
    chk({hv, erase_strobe, mass_strobe}, 3'h6);
    chk(op_addr, 16'h8100);
    @(posedge sys_clk);
    #1;
    chk(erase_strobe, 1'b0);
    drop_hv();
    $display("page erase done");
    do_reset(8'hfe);
    arm(8'h06, 16'h8000);
    chk({hv, erase_strobe, mass_strobe}, 3'h0);
    do_reset(8'hff);
    arm(8'h06, 16'h8000);
    chk({hv, erase_strobe, mass_strobe}, 3'h7);
    chk(op_addr, 16'h8000);
    drop_hv();
    $display("mass erase done");
    do_reset(8'h02);
    arm(8'h01, 16'h8100);
    chk(hv, 1'b0);
    do_reset(8'h02);
    arm(8'h01, 16'h80c0);
    chk(hv, 1'b1);
    rd(16'h80c5);
    chk(rdata, erased_byte);
    wr(16'h80c5, 8'h12);
    chk({program_strobe, row_fail}, 2'h2);
    chk({op_addr, op_data}, 24'h80c512);
    wr(16'h8080, 8'h34);
    chk(row_fail, 1'b1);
    wr(16'h80c6, 8'h56);
    chk(program_strobe, 1'b0);
    drop_hv();
    $display("program done");
    do_reset(8'hff);
    wr(control_addr, 8'h02);
    wr(16'h8000, 8'h00);
    wr(control_addr, 8'h0a);
    chk(hv, 1'b0);
    rd(16'h8000);
    chk(rdata, erased_byte);
    $display("order refusal done");
    print_verdict();
  end

  initial begin
    // about twice the length of the waits and accesses above
    #150000;
    errors++;
    print_verdict();
  end
endmodule
